// file: rtl/universal_shift_register_4bit.sv
`timescale 1ns/1ps

// Summary of operation
// - clear low forces all outputs low
// - clock low, clear high, no soft clear or step: outputs hold
// - besides clear and reset, only a rising clock edge or a control-word step updates register
// - both modes high: edge loads parallel inputs
// - mode 01: shift toward last, right-serial enters
// - mode 10: shift toward first, left-serial enters
// - both modes low: outputs hold
module universal_shift_register_4bit (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic [3:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        we_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// register pins
	input  wire logic        clear_n_i,
	input  wire logic        shift_clk_i,
	input  wire logic        mode_select_upper_i,
	input  wire logic        mode_select_lower_i,
	input  wire logic        serial_left_i,
	input  wire logic        serial_right_i,
	input  wire logic [3:0]  parallel_i,
	// stored bits
	output logic             stored_bit_first_o,
	output logic             stored_bit_second_o,
	output logic             stored_bit_third_o,
	output logic             stored_bit_last_o
);

	logic                                  clk_prev_reg;
	logic                                  clk_prev_next;
	logic                                  clk_en_reg;
	logic                                  clk_en_next;
	logic                                  soft_clear_reg;
	logic                                  soft_clear_next;
	logic                                  step_reg;
	logic                                  step_next;
	logic [shift_reg_pkg::COUNT_W-1:0]     count_reg;
	logic [shift_reg_pkg::COUNT_W-1:0]     count_next;
	logic                                  ack_reg;
	logic                                  ack_next;
	logic [31:0]                           dat_reg;
	logic [31:0]                           dat_next;
	logic                                  clk_rise;
	logic                                  apply;
	logic                                  clear_any;
	logic                                  bus_req;
	logic                                  bus_wr;
	logic [1:0]                            mode;
	logic [3:0]                            q;

	// pins are synchronous to clk_i, so the same sample feeds edge and data
	assign clk_rise  = shift_clk_i & ~clk_prev_reg;
	assign apply     = (clk_rise & clk_en_reg) | step_reg;
	assign clear_any = ~clear_n_i | soft_clear_reg;
	assign mode      = {mode_select_upper_i, mode_select_lower_i};
	assign bus_req   = cyc_i & stb_i & ~ack_reg;
	assign bus_wr    = bus_req & we_i;

	shift_core #(
		.WIDTH(shift_reg_pkg::DATA_W)
	) u_core (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.clear_i    (clear_any),
		.step_i     (apply),
		.mode_i     (mode),
		.ser_left_i (serial_left_i),
		.ser_right_i(serial_right_i),
		.par_i      (parallel_i),
		.q_o        (q)
	);

	// register writes take effect on the cycle the request is seen
	always_comb begin
		clk_prev_next   = shift_clk_i;
		clk_en_next     = clk_en_reg;
		soft_clear_next = soft_clear_reg;
		step_next       = 1'h0;
		count_next      = count_reg;
		if (apply && !clear_any) begin
			count_next = count_reg + 16'h0001;
		end
		if (bus_wr && sel_i[0]) begin
			unique case (adr_i)
				shift_reg_pkg::CTRL_OFS: begin
					clk_en_next     = dat_i[shift_reg_pkg::CTRL_CLK_EN_BIT];
					soft_clear_next = dat_i[shift_reg_pkg::CTRL_CLEAR_BIT];
					step_next       = dat_i[shift_reg_pkg::CTRL_STEP_BIT];
				end
				shift_reg_pkg::COUNT_OFS: begin
					// an edge in the clearing cycle still counts
					count_next = (apply && !clear_any) ? 16'h0001 : 16'h0000;
				end
				default: begin
				end
			endcase
		end
	end

	// bus answers one cycle after the request, unmapped reads give zero
	always_comb begin
		ack_next = bus_req;
		dat_next = dat_reg;
		if (bus_req) begin
			dat_next = 32'h00000000;
			if (!we_i) begin
				unique case (adr_i)
					shift_reg_pkg::CTRL_OFS: begin
						dat_next[shift_reg_pkg::CTRL_CLK_EN_BIT] = clk_en_reg;
						dat_next[shift_reg_pkg::CTRL_CLEAR_BIT]  = soft_clear_reg;
					end
					shift_reg_pkg::STATUS_OFS: begin
						dat_next[shift_reg_pkg::STAT_Q_LSB +: 4]    = q;
						dat_next[shift_reg_pkg::STAT_MODE_LSB +: 2] = mode;
						dat_next[shift_reg_pkg::STAT_CLEAR_BIT]     = clear_n_i;
						dat_next[shift_reg_pkg::STAT_CLK_BIT]       = shift_clk_i;
					end
					shift_reg_pkg::COUNT_OFS: begin
						dat_next[shift_reg_pkg::COUNT_W-1:0] = count_reg;
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_prev_reg   <= 1'h0;
			clk_en_reg     <= shift_reg_pkg::CTRL_CLK_EN_RST;
			soft_clear_reg <= shift_reg_pkg::CTRL_CLEAR_RST;
			step_reg       <= 1'h0;
			count_reg      <= shift_reg_pkg::COUNT_RST;
			ack_reg        <= 1'h0;
			dat_reg        <= 32'h00000000;
		end else begin
			clk_prev_reg   <= clk_prev_next;
			clk_en_reg     <= clk_en_next;
			soft_clear_reg <= soft_clear_next;
			step_reg       <= step_next;
			count_reg      <= count_next;
			ack_reg        <= ack_next;
			dat_reg        <= dat_next;
		end
	end

	assign ack_o               = ack_reg;
	assign dat_o               = dat_reg;
	assign stored_bit_first_o  = q[0];
	assign stored_bit_second_o = q[1];
	assign stored_bit_third_o  = q[2];
	assign stored_bit_last_o   = q[3];

	// clear is seen one clk_i edge later, not truly asynchronous
	chk_clear_zeroes_all: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!clear_n_i |=> (q == 4'h0) ##0 !stored_bit_last_o)
		else $error("clear did not force outputs low");

	chk_low_clock_holds: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(clear_n_i && !soft_clear_reg && !shift_clk_i && !step_reg) |=> $stable(q))
		else $error("outputs moved while shift clock low");

	chk_high_fall_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(clear_n_i && !soft_clear_reg && !step_reg && clk_prev_reg) |=> $stable(q))
		else $error("outputs moved without a rising shift clock");

	chk_parallel_load: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(apply && !clear_any && mode == 2'h3) |=> (q == $past(parallel_i)))
		else $error("parallel load mismatch");

	chk_shift_right: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(apply && !clear_any && mode == 2'h1)
		|=> (q == {$past(q[2:0]), $past(serial_right_i)}))
		else $error("right shift mismatch");

	chk_shift_left: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(apply && !clear_any && mode == 2'h2)
		|=> (q == {$past(serial_left_i), $past(q[3:1])}))
		else $error("left shift mismatch");

	chk_mode_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!clear_any && mode == 2'h0) [*2] |=> $stable(q))
		else $error("outputs moved in hold mode");

	// soft clear acts like the pin, one clk_i edge later
	chk_soft_clear_zero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		soft_clear_reg |=> (q == 4'h0))
		else $error("soft clear did not force outputs low");

	chk_gated_edge_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!clk_en_reg && !step_reg && !clear_any) |=> $stable(q))
		else $error("outputs moved with pin edges gated off");

	chk_count_advance: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(apply && !clear_any && !(bus_wr && sel_i[0] && adr_i == shift_reg_pkg::COUNT_OFS))
		|=> (count_reg == $past(count_reg) + 16'h0001))
		else $error("applied edge not counted");

	chk_bus_ack_pulse: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("bus ack not a single pulse");

endmodule

// file: rtl/shift_reg_pkg.sv
package shift_reg_pkg;

	// register data width
	localparam int DATA_W = 4;

	// bus geometry
	localparam int ADR_W = 4;
	localparam int WB_W  = 32;

	// byte offsets of the register words
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] COUNT_OFS  = 4'h8;

	// control word fields
	localparam int CTRL_CLK_EN_BIT = 0;
	localparam int CTRL_CLEAR_BIT  = 1;
	localparam int CTRL_STEP_BIT   = 2;
	localparam logic CTRL_CLK_EN_RST = 1'h1;
	localparam logic CTRL_CLEAR_RST  = 1'h0;

	// status word fields
	localparam int STAT_Q_LSB     = 0;
	localparam int STAT_MODE_LSB  = 4;
	localparam int STAT_CLEAR_BIT = 6;
	localparam int STAT_CLK_BIT   = 7;

	// applied-edge counter
	localparam int COUNT_W = 16;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	// mode select pair {upper, lower}
	typedef enum logic [1:0] {
		MODE_HOLD  = 2'h0,
		MODE_RIGHT = 2'h1,
		MODE_LEFT  = 2'h2,
		MODE_LOAD  = 2'h3
	} mode_t;

endpackage

// file: rtl/shift_core.sv
`timescale 1ns/1ps

module shift_core #(
	parameter int WIDTH = shift_reg_pkg::DATA_W
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// control
	input  wire logic               clear_i,
	input  wire logic               step_i,
	input  wire logic [1:0]         mode_i,
	// data in
	input  wire logic               ser_left_i,
	input  wire logic               ser_right_i,
	input  wire logic [WIDTH-1:0]   par_i,
	// stored bits, bit 0 is the first
	output logic      [WIDTH-1:0]   q_o
);

	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] q_next;

	always_comb begin
		q_next = q_reg;
		if (clear_i) begin
			q_next = '0;
		end else if (step_i) begin
			unique case (shift_reg_pkg::mode_t'(mode_i))
				shift_reg_pkg::MODE_HOLD: begin
					q_next = q_reg;
				end
				shift_reg_pkg::MODE_RIGHT: begin
					q_next = {q_reg[WIDTH-2:0], ser_right_i};
				end
				shift_reg_pkg::MODE_LEFT: begin
					q_next = {ser_left_i, q_reg[WIDTH-1:1]};
				end
				shift_reg_pkg::MODE_LOAD: begin
					q_next = par_i;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q_o = q_reg;

endmodule

// file: testbench/pin_driver.sv
`timescale 1ns/1ps

module pin_driver (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// request from the bench
	input  wire logic       req_i,
	input  wire logic [1:0] mode_i,
	input  wire logic [5:0] data_i,
	// pins toward the register, and busy back to the bench
	output logic            shift_clk_o,
	output logic      [1:0] mode_o,
	output logic      [5:0] data_o,
	output logic            busy_o
);
	logic [1:0] phase;

	// one low-high-low clock pulse per request
	always @(posedge clk_i) begin
		if (rst_i) begin
			busy_o      <= 1'h0;
			shift_clk_o <= 1'h0;
			phase       <= 2'h0;
			mode_o      <= 2'h0;
			data_o      <= 6'h00;
		end else if (!busy_o && req_i) begin
			// pins settle a cycle before the clock rises and stay put after
			mode_o <= mode_i;
			data_o <= data_i;
			busy_o <= 1'h1;
			phase  <= 2'h0;
		end else if (busy_o) begin
			phase       <= phase + 2'h1;
			shift_clk_o <= (phase == 2'h0);
			busy_o      <= (phase != 2'h2);
		end
	end
endmodule

// file: testbench/universal_shift_register_4bit_test.sv
`timescale 1ns/1ps

module universal_shift_register_4bit_test;
	logic        clk_i;
	logic        rst_i;
	logic [3:0]  adr_i;
	logic [31:0] dat_i;
	logic [3:0]  sel_i;
	logic        we_i;
	logic        cyc_i;
	logic        stb_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        clear_n_i;
	logic        shift_clk;
	logic [1:0]  mode;
	logic [5:0]  pins;
	logic        req;
	logic [1:0]  req_mode;
	logic [5:0]  req_data;
	logic        busy;
	logic [3:0]  q;
	logic [31:0] r;
	int          miscompares;
	int          checks_done;

	universal_shift_register_4bit universal_shift_register_4bit_inst (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
		.we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.clear_n_i(clear_n_i), .shift_clk_i(shift_clk),
		.mode_select_upper_i(mode[1]), .mode_select_lower_i(mode[0]),
		.serial_left_i(pins[5]), .serial_right_i(pins[4]), .parallel_i(pins[3:0]),
		.stored_bit_first_o(q[0]), .stored_bit_second_o(q[1]),
		.stored_bit_third_o(q[2]), .stored_bit_last_o(q[3]));

	pin_driver pin_driver_inst (
		.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .mode_i(req_mode), .data_i(req_data),
		.shift_clk_o(shift_clk), .mode_o(mode), .data_o(pins), .busy_o(busy));

	always #20 clk_i = ~clk_i;

	task automatic summarize();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 50);
		if (ack_o !== 1'h1) begin
			miscompares++;
			summarize();
		end
		r = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i  <= 1'h0;
		@(posedge clk_i);
	endtask

	// one pulse on the pins, then compare the stored bits
	task automatic step(input logic [1:0] m, input logic [5:0] d, input logic [3:0] exp);
		int n;
		req      <= 1'h1;
		req_mode <= m;
		req_data <= d;
		@(posedge clk_i);
		req <= 1'h0;
		@(posedge clk_i);
		for (n = 0; n < 20 && busy; n++)
			@(posedge clk_i);
		if (busy) begin
			miscompares++;
			summarize();
		end
		check("stored bits", {28'h0, q}, {28'h0, exp});
	endtask

	initial begin
		clk_i = 1'h0;
		rst_i = 1'h1;
		{adr_i, dat_i, we_i, cyc_i, stb_i, req, req_mode, req_data} = '0;
		sel_i = 4'hF;
		clear_n_i = 1'h1;
		miscompares = 0;
		checks_done = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, shift_reg_pkg::STATUS_OFS, 32'h0);
		check("status", r, 32'h00000040);
		$display("test reset done");
		step(2'h3, 6'h0A, 4'hA);
		step(2'h1, 6'h15, 4'h5);
		step(2'h2, 6'h0F, 4'h2);
		step(2'h2, 6'h20, 4'h9);
		wb(1'h0, shift_reg_pkg::COUNT_OFS, 32'h0);
		check("count", r, 32'h00000004);
		step(2'h0, 6'h3F, 4'h9);
		$display("test modes done");
		clear_n_i <= 1'h0;
		step(2'h3, 6'h0F, 4'h0);
		clear_n_i <= 1'h1;
		$display("test clear done");
		wb(1'h1, shift_reg_pkg::CTRL_OFS, 32'h0);
		step(2'h3, 6'h06, 4'h0);
		wb(1'h1, shift_reg_pkg::CTRL_OFS, 32'h5);
		wb(1'h0, shift_reg_pkg::STATUS_OFS, 32'h0);
		check("status", r, 32'h00000076);
		wb(1'h1, shift_reg_pkg::CTRL_OFS, 32'h3);
		wb(1'h0, shift_reg_pkg::CTRL_OFS, 32'h0);
		check("control", r, 32'h00000003);
		wb(1'h0, shift_reg_pkg::STATUS_OFS, 32'h0);
		check("status", r, 32'h00000070);
		wb(1'h1, shift_reg_pkg::CTRL_OFS, 32'h1);
		wb(1'h1, shift_reg_pkg::COUNT_OFS, 32'h0);
		wb(1'h0, shift_reg_pkg::COUNT_OFS, 32'h0);
		check("count", r, 32'h0);
		wb(1'h0, 4'hC, 32'h0);
		check("unmapped", r, 32'h0);
		$display("test registers done");
		step(2'h3, 6'h39, 4'h9);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		check("stored bits", {28'h0, q}, 32'h0);
		sel_i <= 4'h0;
		wb(1'h1, shift_reg_pkg::CTRL_OFS, 32'h0);
		sel_i <= 4'hF;
		wb(1'h0, shift_reg_pkg::CTRL_OFS, 32'h0);
		check("control", r, 32'h00000001);
		wb(1'h0, shift_reg_pkg::COUNT_OFS, 32'h0);
		check("count", r, 32'h0);
		$display("test reset again done");
		summarize();
	end
endmodule
